// [dual_supply_reset_supervisor.sv]
`timescale 1ns/100ps
`default_nettype none
// Operation
// - out-of-tolerance supply drives its own reset low at once
// - after return to tolerance, reset holds for selected delay, then releases
// - at power-up each reset held until in tolerance plus delay
// - low-rail tolerance strap: tied high 5%, ground 10%, float 15%
// - high-rail tolerance strap: tied high 5%, ground 10%, float 20%
// - tolerance straps sampled once at power-up and held
// - delay strap: ground 10 ms, float 100 ms, high 1000 ms minimum
// - delay straps captured at power-up, frozen once in tolerance
// - supply button held low 20 us while reset inactive starts a reset
// - supply button low forces reset; one delay after release
// - master button drives all resets and interrupts low together
// - master cycle starts only if an input in tolerance and output active
// - master button needs 20 us low; outputs hold their delay after release
// - master button debounced inside before use
// - master-caused reset drives last-source low until another source resets
// - once cleared, last-source stays high until next master reset
// - neither supply above 1.5 V holds both resets and both interrupts active
// - sense trip pulses its interrupt active at least 10 us
// - sense must stay below trip about 2 us before interrupt goes low
// - interrupt held low while sense below trip, released above it
// - interrupts held low at power-up until a supply reaches 1.5 V
module dual_supply_reset_supervisor #(
	parameter int P_DELAY_SHORT_CYC = supervisor_pkg::DELAY_SHORT_CYC,
	parameter int P_DELAY_MID_CYC = supervisor_pkg::DELAY_MID_CYC,
	parameter int P_DELAY_LONG_CYC = supervisor_pkg::DELAY_LONG_CYC
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_reset,
	// rail comparator flags
	input wire logic i_low_rail_supply_ok,
	input wire logic i_high_rail_supply_ok,
	input wire logic i_low_rail_above_1v5,
	input wire logic i_high_rail_above_1v5,
	// sense comparator flags, high above sense_trip_level
	input wire logic i_sense_input_a_ok,
	input wire logic i_sense_input_b_ok,
	// strap pins
	input wire logic [1:0] i_low_tolerance_strap,
	input wire logic [1:0] i_high_tolerance_strap,
	input wire logic [1:0] i_low_delay_select_strap,
	input wire logic [1:0] i_high_delay_select_strap,
	// pushbutton pins
	input wire logic i_low_supply_pushbutton_n,
	input wire logic i_high_supply_pushbutton_n,
	input wire logic i_master_pushbutton_n,
	// tolerance selection to the rail comparators
	output logic [1:0] o_low_tol_sel,
	output logic [1:0] o_high_tol_sel,
	// open-drain reset outputs
	output logic o_low_reset_n,
	output logic o_low_reset_n_oe,
	output logic o_high_reset_n,
	output logic o_high_reset_n_oe,
	// open-drain early-warning interrupts
	output logic o_nmi_a_n,
	output logic o_nmi_a_n_oe,
	output logic o_nmi_b_n,
	output logic o_nmi_b_n_oe,
	// open-drain last reset source
	output logic o_last_reset_source_n,
	output logic o_last_reset_source_n_oe
);
	localparam int TW = supervisor_pkg::TIMER_W;
	localparam int PBW = supervisor_pkg::PB_CNT_W;
	localparam int FLW = supervisor_pkg::FILT_CNT_W;
	localparam int NPIN = 11;
	localparam logic [NPIN-1:0] PIN_RST = 11'h007;

	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] sync1_q;
	logic [NPIN-1:0] sync2_q;
	logic [2:0] pb_low;
	logic [2:0] pb_pressed;
	logic [1:0] sense_below;
	logic [1:0] sense_low;
	logic [1:0] fill_q;
	logic straps_ready;
	logic tol_done_q;
	logic reached_q;
	logic [1:0] low_tol_q;
	logic [1:0] high_tol_q;
	logic [1:0] low_delay_q;
	logic [1:0] high_delay_q;
	logic [1:0] low_tol_map;
	logic [1:0] high_tol_map;
	logic [TW-1:0] low_delay_cnt;
	logic [TW-1:0] high_delay_cnt;
	logic power_ok;
	logic force_all;
	logic master_force;
	logic [1:0] pb_cycle_q;
	logic [1:0] pb_cycle_d;
	logic [1:0] rst_active;
	logic [1:0] nmi_active;
	logic low_force;
	logic high_force;
	logic [1:0] nmi_force;
	logic any_tol;
	logic any_active;
	logic mpb_start;
	supervisor_pkg::mpb_state_t mpb_state_q;
	supervisor_pkg::mpb_state_t mpb_state_d;
	logic other_src;
	logic other_q;
	logic lrs_clr;
	logic lrs_low_q;
	logic lrs_low_d;

	// pins are asynchronous to the timebase
	assign pin_raw = {i_high_delay_select_strap, i_low_delay_select_strap,
		i_high_tolerance_strap, i_low_tolerance_strap,
		i_master_pushbutton_n, i_high_supply_pushbutton_n,
		i_low_supply_pushbutton_n};

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			sync1_q <= PIN_RST;
			sync2_q <= PIN_RST;
		end
		else
		begin
			sync1_q <= pin_raw;
			sync2_q <= sync1_q;
		end
	end

	assign pb_low = ~sync2_q[2:0];
	assign sense_below = {~i_sense_input_b_ok, ~i_sense_input_a_ok};

	// one low-width filter per button; release acts at once
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : gen_pb
			logic [supervisor_pkg::PB_CNT_W-1:0] cnt_q;
			logic at_min;
			assign at_min = (cnt_q == supervisor_pkg::PB_MIN_CNT);
			assign pb_pressed[gi] = at_min;
			always_ff @(posedge i_mclk or posedge i_reset)
			begin
				if (i_reset)
					cnt_q <= '0;
				else if (!pb_low[gi])
					cnt_q <= '0;
				else if (!at_min)
					cnt_q <= cnt_q + PBW'(1);
			end
		end
	endgenerate

	// sense glitch filter rejects supply noise
	generate
		for (gi = 0; gi < 2; gi++)
		begin : gen_sense
			logic [supervisor_pkg::FILT_CNT_W-1:0] cnt_q;
			logic at_min;
			assign at_min = (cnt_q == supervisor_pkg::FILTER_CNT);
			assign sense_low[gi] = at_min;
			always_ff @(posedge i_mclk or posedge i_reset)
			begin
				if (i_reset)
					cnt_q <= '0;
				else if (!sense_below[gi])
					cnt_q <= '0;
				else if (!at_min)
					cnt_q <= cnt_q + FLW'(1);
			end
		end
	endgenerate

	// straps are valid only once the synchroniser has filled
	assign straps_ready = fill_q[1];
	assign power_ok = i_low_rail_above_1v5 | i_high_rail_above_1v5;

	assign low_tol_map =
		(sync2_q[4:3] == supervisor_pkg::STRAP_HIGH) ? supervisor_pkg::TOL_5 :
		(sync2_q[4:3] == supervisor_pkg::STRAP_GND) ? supervisor_pkg::TOL_10 :
		supervisor_pkg::TOL_15;
	assign high_tol_map =
		(sync2_q[6:5] == supervisor_pkg::STRAP_HIGH) ? supervisor_pkg::TOL_5 :
		(sync2_q[6:5] == supervisor_pkg::STRAP_GND) ? supervisor_pkg::TOL_10 :
		supervisor_pkg::TOL_20;

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			fill_q <= 2'h0;
			tol_done_q <= 1'b0;
			low_tol_q <= supervisor_pkg::TOL_5;
			high_tol_q <= supervisor_pkg::TOL_5;
		end
		else
		begin
			fill_q <= {fill_q[0], 1'b1};
			if (straps_ready && !tol_done_q)
			begin
				tol_done_q <= 1'b1;
				low_tol_q <= low_tol_map;
				high_tol_q <= high_tol_map;
			end
		end
	end

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			reached_q <= 1'b0;
			low_delay_q <= supervisor_pkg::STRAP_GND;
			high_delay_q <= supervisor_pkg::STRAP_GND;
		end
		else if (straps_ready && !reached_q)
		begin
			low_delay_q <= sync2_q[8:7];
			high_delay_q <= sync2_q[10:9];
			reached_q <= power_ok & (i_low_rail_supply_ok | i_high_rail_supply_ok);
		end
	end

	assign o_low_tol_sel = low_tol_q;
	assign o_high_tol_sel = high_tol_q;

	// the minimum figure is taken; it sits inside the allowed band
	assign low_delay_cnt =
		(low_delay_q == supervisor_pkg::STRAP_GND) ? TW'(P_DELAY_SHORT_CYC) :
		(low_delay_q == supervisor_pkg::STRAP_FLOAT) ? TW'(P_DELAY_MID_CYC) :
		TW'(P_DELAY_LONG_CYC);
	assign high_delay_cnt =
		(high_delay_q == supervisor_pkg::STRAP_GND) ? TW'(P_DELAY_SHORT_CYC) :
		(high_delay_q == supervisor_pkg::STRAP_FLOAT) ? TW'(P_DELAY_MID_CYC) :
		TW'(P_DELAY_LONG_CYC);

	// supply button cycle may only begin while its reset is released
	assign pb_cycle_d = pb_pressed[1:0] & (pb_cycle_q | ~rst_active);

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			pb_cycle_q <= 2'h0;
		else
			pb_cycle_q <= pb_cycle_d;
	end

	assign force_all = ~power_ok | ~tol_done_q;
	assign master_force = (mpb_state_q == supervisor_pkg::MPB_HELD);
	assign low_force = ~i_low_rail_supply_ok | force_all | master_force |
		pb_cycle_q[0];
	assign high_force = ~i_high_rail_supply_ok | force_all | master_force |
		pb_cycle_q[1];
	assign nmi_force = sense_low | {2{force_all | master_force}};

	hold_timer #(
		.W(TW)
	) u_low_rst (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_force(low_force),
		.i_delay(low_delay_cnt),
		.o_active(rst_active[0])
	);

	hold_timer #(
		.W(TW)
	) u_high_rst (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_force(high_force),
		.i_delay(high_delay_cnt),
		.o_active(rst_active[1])
	);

	generate
		for (gi = 0; gi < 2; gi++)
		begin : gen_nmi
			hold_timer #(
				.W(TW)
			) u_nmi (
				.i_mclk(i_mclk),
				.i_reset(i_reset),
				.i_force(nmi_force[gi]),
				.i_delay(supervisor_pkg::NMI_PULSE_CNT),
				.o_active(nmi_active[gi])
			);
		end
	endgenerate

	// master cycle
	assign any_tol = i_low_rail_supply_ok | i_high_rail_supply_ok |
		i_sense_input_a_ok | i_sense_input_b_ok;
	assign any_active = |{rst_active, nmi_active};
	assign mpb_start = pb_pressed[2] & any_tol & any_active;

	always_comb
	begin
		mpb_state_d = mpb_state_q;
		case (mpb_state_q)
			supervisor_pkg::MPB_IDLE:
				if (mpb_start)
					mpb_state_d = supervisor_pkg::MPB_HELD;
			supervisor_pkg::MPB_HELD:
				if (!pb_pressed[2])
					mpb_state_d = supervisor_pkg::MPB_IDLE;
			default:
				mpb_state_d = supervisor_pkg::MPB_IDLE;
		endcase
	end

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			mpb_state_q <= supervisor_pkg::MPB_IDLE;
		else
			mpb_state_q <= mpb_state_d;
	end

	// last reset source; a master start beats a clear in the same cycle
	assign other_src = ~i_low_rail_supply_ok | ~i_high_rail_supply_ok |
		(|pb_cycle_q);
	assign lrs_clr = other_src & ~other_q;
	assign lrs_low_d = (mpb_start && mpb_state_q == supervisor_pkg::MPB_IDLE) |
		(lrs_low_q & ~lrs_clr);

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			other_q <= 1'b1;
			lrs_low_q <= 1'b0;
		end
		else
		begin
			other_q <= other_src;
			lrs_low_q <= lrs_low_d;
		end
	end

	// open-drain pins only ever pull low
	assign o_low_reset_n = 1'b0;
	assign o_high_reset_n = 1'b0;
	assign o_nmi_a_n = 1'b0;
	assign o_nmi_b_n = 1'b0;
	assign o_last_reset_source_n = 1'b0;
	assign o_low_reset_n_oe = rst_active[0];
	assign o_high_reset_n_oe = rst_active[1];
	assign o_nmi_a_n_oe = nmi_active[0];
	assign o_nmi_b_n_oe = nmi_active[1];
	assign o_last_reset_source_n_oe = lrs_low_q;

	property p_oot_reset;
		@(posedge i_mclk) disable iff (i_reset)
		!i_low_rail_supply_ok |=> o_low_reset_n_oe;
	endproperty
	a_oot_reset: assert property (p_oot_reset)
		else $error("low reset not driven on out of tolerance");

	property p_low_power;
		@(posedge i_mclk) disable iff (i_reset)
		!power_ok |=> o_low_reset_n_oe && o_high_reset_n_oe &&
			o_nmi_a_n_oe && o_nmi_b_n_oe;
	endproperty
	a_low_power: assert property (p_low_power)
		else $error("outputs released below valid supply");

	property p_tol_hold;
		@(posedge i_mclk) disable iff (i_reset)
		tol_done_q && $past(tol_done_q) |->
			$stable(o_low_tol_sel) && $stable(o_high_tol_sel);
	endproperty
	a_tol_hold: assert property (p_tol_hold)
		else $error("tolerance changed after capture");

	property p_tol_float;
		@(posedge i_mclk) disable iff (i_reset)
		$rose(tol_done_q) && $past(sync2_q[6:5]) == supervisor_pkg::STRAP_FLOAT
			|-> o_high_tol_sel == supervisor_pkg::TOL_20;
	endproperty
	a_tol_float: assert property (p_tol_float)
		else $error("floating high tolerance strap not 20 percent");

	property p_delay_freeze;
		@(posedge i_mclk) disable iff (i_reset)
		reached_q && $past(reached_q) |->
			$stable(low_delay_q) && $stable(high_delay_q);
	endproperty
	a_delay_freeze: assert property (p_delay_freeze)
		else $error("delay strap changed after tolerance reached");

	property p_pb_gate;
		@(posedge i_mclk) disable iff (i_reset)
		$rose(pb_cycle_q[0]) |-> $past(pb_pressed[0]) && !$past(rst_active[0]);
	endproperty
	a_pb_gate: assert property (p_pb_gate)
		else $error("supply button cycle started while reset active");

	property p_pb_width;
		@(posedge i_mclk) disable iff (i_reset)
		$rose(pb_pressed[2]) |-> $past(pb_low[2], 1) && $past(pb_low[2], 8);
	endproperty
	a_pb_width: assert property (p_pb_width)
		else $error("short button pulse accepted");

	property p_master_all;
		@(posedge i_mclk) disable iff (i_reset)
		master_force |=> o_low_reset_n_oe && o_high_reset_n_oe &&
			o_nmi_a_n_oe && o_nmi_b_n_oe;
	endproperty
	a_master_all: assert property (p_master_all)
		else $error("master cycle left an output released");

	property p_master_gate;
		@(posedge i_mclk) disable iff (i_reset)
		$rose(master_force) |-> $past(any_tol) && $past(any_active);
	endproperty
	a_master_gate: assert property (p_master_gate)
		else $error("master cycle started without qualifying state");

	property p_lrs_set;
		@(posedge i_mclk) disable iff (i_reset)
		$rose(master_force) |-> o_last_reset_source_n_oe;
	endproperty
	a_lrs_set: assert property (p_lrs_set)
		else $error("last source not marked by master reset");

	property p_lrs_clear;
		@(posedge i_mclk) disable iff (i_reset)
		$fell(lrs_low_q) |-> $past(lrs_clr);
	endproperty
	a_lrs_clear: assert property (p_lrs_clear)
		else $error("last source cleared without other reset");

	property p_nmi_filter;
		@(posedge i_mclk) disable iff (i_reset)
		!sense_below[0] ##1 sense_below[0] [*8] |-> !sense_low[0];
	endproperty
	a_nmi_filter: assert property (p_nmi_filter)
		else $error("sense trip not filtered");

	c_master: cover property (@(posedge i_mclk) $rose(master_force));
	c_pb_cycle: cover property (@(posedge i_mclk) $rose(pb_cycle_q[1]));
	c_nmi_trip: cover property (@(posedge i_mclk) $rose(sense_low[1]));
	c_lrs_clear: cover property (@(posedge i_mclk) $fell(lrs_low_q));
endmodule // dual_supply_reset_supervisor
`default_nettype wire

// [hold_timer.sv]
`timescale 1ns/100ps
`default_nettype none
package supervisor_pkg;
	localparam int CLK_PERIOD_NS = 40;
	localparam int CLK_KHZ = 25000;
	localparam int DELAY_SHORT_MS = 10;
	localparam int DELAY_MID_MS = 100;
	localparam int DELAY_LONG_MS = 1000;
	localparam int DELAY_SHORT_CYC = DELAY_SHORT_MS * CLK_KHZ;
	localparam int DELAY_MID_CYC = DELAY_MID_MS * CLK_KHZ;
	localparam int DELAY_LONG_CYC = DELAY_LONG_MS * CLK_KHZ;
	localparam int PB_MIN_NS = 20000;
	localparam int PB_MIN_CYC = (PB_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NMI_PULSE_NS = 10000;
	localparam int NMI_PULSE_CYC =
		(NMI_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILTER_NS = 2000;
	localparam int FILTER_CYC = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_W = 25;
	localparam int PB_CNT_W = 9;
	localparam int FILT_CNT_W = 6;
	localparam logic [PB_CNT_W-1:0] PB_MIN_CNT = PB_CNT_W'(PB_MIN_CYC);
	localparam logic [FILT_CNT_W-1:0] FILTER_CNT = FILT_CNT_W'(FILTER_CYC);
	localparam logic [TIMER_W-1:0] NMI_PULSE_CNT = TIMER_W'(NMI_PULSE_CYC);
	// strap codes from the three-level pin detector
	localparam logic [1:0] STRAP_GND = 2'h0;
	localparam logic [1:0] STRAP_HIGH = 2'h1;
	localparam logic [1:0] STRAP_FLOAT = 2'h2;
	// tolerance selection to the rail comparators
	localparam logic [1:0] TOL_5 = 2'h0;
	localparam logic [1:0] TOL_10 = 2'h1;
	localparam logic [1:0] TOL_15 = 2'h2;
	localparam logic [1:0] TOL_20 = 2'h3;
	typedef enum logic [0:0] {
		MPB_IDLE = 1'b0,
		MPB_HELD = 1'b1
	} mpb_state_t;
endpackage

module hold_timer #(
	parameter int W = supervisor_pkg::TIMER_W
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_reset,
	// control
	input wire logic i_force,
	input wire logic [W-1:0] i_delay,
	// state
	output logic o_active
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic active_q;
	logic active_d;
	logic cnt_run;

	assign cnt_run = (cnt_q > W'(1));
	assign cnt_d = i_force ? i_delay : (cnt_q != '0 ? cnt_q - W'(1) : cnt_q);
	assign active_d = i_force | cnt_run;
	assign o_active = active_q;

	// starts active so nothing escapes before the first force
	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			cnt_q <= '0;
			active_q <= 1'b1;
		end
		else
		begin
			cnt_q <= cnt_d;
			active_q <= active_d;
		end
	end

	property p_release_after_count;
		@(posedge i_mclk) disable iff (i_reset)
		$fell(active_q) |-> ($past(cnt_q) <= W'(1)) && !$past(i_force);
	endproperty
	a_release_after_count: assert property (p_release_after_count)
		else $error("output released before delay ran out");

	property p_hold_while_forced;
		@(posedge i_mclk) disable iff (i_reset)
		i_force |=> active_q [*2];
	endproperty
	a_hold_while_forced: assert property (p_hold_while_forced)
		else $error("output not held after force");
endmodule // hold_timer
`default_nettype wire

// [sys_side_model.sv]
`timescale 1ns/100ps
`default_nettype none
// processor side: pull-ups on every open-drain line it receives
module sys_side_model (
	// drive values and enables from the supervisor
	input wire logic [4:0] i_drive,
	input wire logic [4:0] i_oe,
	// resolved wire levels seen by the processor
	output logic [4:0] o_level
);
	// a released line floats to its pull-up, never the last driven value
	assign o_level = (i_oe & i_drive) | ~i_oe;
endmodule // sys_side_model
`default_nettype wire

// [tb_dual_supply_reset_supervisor.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_dual_supply_reset_supervisor;
	localparam int LIMIT = 14000;
	logic i_mclk = 1'b0;
	logic i_reset = 1'b1;
	logic low_ok = 1'b1, high_ok = 1'b1, low_1v5 = 1'b0, high_1v5 = 1'b0;
	logic [1:0] sense_ok = 2'h3;
	logic [1:0] low_tol = 2'h0, high_tol = 2'h0, low_td = 2'h0, high_td = 2'h0;
	logic low_pb_n = 1'b1, high_pb_n = 1'b1, master_pb_n = 1'b1;
	logic [1:0] o_low_tol_sel, o_high_tol_sel;
	logic [4:0] drive, oe, lvl;
	logic [1:0] exp_lt, exp_ht;
	logic [8:0] notes[$];
	logic [31:0] seed = 32'h0ebdb5c5;
	int bad_count = 0, checks = 0, cycle = 0;
	logic [1:0] lt_tab[3] = '{supervisor_pkg::TOL_10, supervisor_pkg::TOL_5,
		supervisor_pkg::TOL_15};
	logic [1:0] ht_tab[3] = '{supervisor_pkg::TOL_10, supervisor_pkg::TOL_5,
		supervisor_pkg::TOL_20};
	// short delays keep the run brief: ground 20, float 40, high 80
	int dly_tab[3] = '{20, 80, 40};

	always #20 i_mclk = ~i_mclk;

	dual_supply_reset_supervisor #(
		.P_DELAY_SHORT_CYC(20),
		.P_DELAY_MID_CYC(40),
		.P_DELAY_LONG_CYC(80)
	) dual_supply_reset_supervisor_inst (
		.i_mclk(i_mclk), .i_reset(i_reset),
		.i_low_rail_supply_ok(low_ok), .i_high_rail_supply_ok(high_ok),
		.i_low_rail_above_1v5(low_1v5), .i_high_rail_above_1v5(high_1v5),
		.i_sense_input_a_ok(sense_ok[0]), .i_sense_input_b_ok(sense_ok[1]),
		.i_low_tolerance_strap(low_tol), .i_high_tolerance_strap(high_tol),
		.i_low_delay_select_strap(low_td), .i_high_delay_select_strap(high_td),
		.i_low_supply_pushbutton_n(low_pb_n),
		.i_high_supply_pushbutton_n(high_pb_n),
		.i_master_pushbutton_n(master_pb_n),
		.o_low_tol_sel(o_low_tol_sel), .o_high_tol_sel(o_high_tol_sel),
		.o_low_reset_n(drive[4]), .o_low_reset_n_oe(oe[4]),
		.o_high_reset_n(drive[3]), .o_high_reset_n_oe(oe[3]),
		.o_nmi_a_n(drive[2]), .o_nmi_a_n_oe(oe[2]),
		.o_nmi_b_n(drive[1]), .o_nmi_b_n_oe(oe[1]),
		.o_last_reset_source_n(drive[0]),
		.o_last_reset_source_n_oe(oe[0])
	);

	sys_side_model sys_side_model_inst (
		.i_drive(drive),
		.i_oe(oe),
		.o_level(lvl)
	);

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("mismatches %0d comparisons %0d", bad_count, checks);
		if (bad_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic wait_c(input int n);
		repeat (n) @(posedge i_mclk);
	endtask

	// levels {low rst, high rst, nmi a, nmi b, last source}, 1 = released
	task automatic note(input logic [4:0] v);
		notes.push_back({v, exp_lt, exp_ht});
		@(posedge i_mclk);
	endtask

	// watcher compares each settled result against the oldest note
	always @(negedge i_mclk)
		if (notes.size() > 0)
			check({lvl, o_low_tol_sel, o_high_tol_sel}, notes.pop_front());

	always @(posedge i_mclk)
	begin
		cycle++;
		if (cycle >= LIMIT)
		begin
			bad_count++;
			complete_run();
		end
	end

	initial
	begin
		for (int k = 0; k < 3; k++)
		begin
			@(posedge i_mclk);
			i_reset <= 1'b1;
			low_1v5 <= 1'b0;
			high_1v5 <= 1'b0;
			low_tol <= 2'(k);
			high_tol <= 2'(k);
			low_td <= 2'(k);
			high_td <= 2'(k);
			wait_c(5);
			i_reset <= 1'b0;
			exp_lt = lt_tab[k];
			exp_ht = ht_tab[k];
			wait_c(28);
			note(5'b00001);
			low_1v5 <= 1'b1;
			high_1v5 <= 1'b1;
			wait_c(dly_tab[k] - 2);
			note(5'b00001);
			wait_c(12);
			note(5'b11001);
			wait_c(300);
			note(5'b11111);
		end
		// straps moved after capture must change nothing
		seed = xs(seed);
		low_tol <= seed[1:0];
		high_tol <= seed[3:2];
		low_td <= seed[5:4];
		high_td <= seed[7:6];
		wait_c(10);
		note(5'b11111);
		low_ok <= 1'b0;
		wait_c(3);
		note(5'b01111);
		wait_c(20);
		low_ok <= 1'b1;
		wait_c(38);
		note(5'b01111);
		wait_c(12);
		note(5'b11111);
		low_pb_n <= 1'b0;
		wait_c(400);
		low_pb_n <= 1'b1;
		wait_c(5);
		note(5'b11111);
		low_pb_n <= 1'b0;
		wait_c(510);
		note(5'b01111);
		wait_c(100);
		note(5'b01111);
		low_pb_n <= 1'b1;
		wait_c(36);
		note(5'b01111);
		wait_c(14);
		note(5'b11111);
		master_pb_n <= 1'b0;
		wait_c(600);
		master_pb_n <= 1'b1;
		wait_c(5);
		note(5'b11111);
		high_ok <= 1'b0;
		master_pb_n <= 1'b0;
		wait_c(100);
		master_pb_n <= 1'b1;
		wait_c(5);
		note(5'b10111);
		master_pb_n <= 1'b0;
		wait_c(510);
		note(5'b00000);
		high_ok <= 1'b1;
		wait_c(20);
		master_pb_n <= 1'b1;
		wait_c(36);
		note(5'b00000);
		wait_c(20);
		note(5'b11000);
		wait_c(250);
		note(5'b11110);
		low_ok <= 1'b0;
		wait_c(5);
		note(5'b01111);
		low_ok <= 1'b1;
		wait_c(60);
		note(5'b11111);
		for (int c = 0; c < 2; c++)
		begin
			sense_ok[c] <= 1'b0;
			wait_c(30);
			sense_ok[c] <= 1'b1;
			wait_c(5);
			note(5'b11111);
			sense_ok[c] <= 1'b0;
			wait_c(60);
			note(5'b11111 & ~(5'b00100 >> c));
			wait_c(400);
			note(5'b11111 & ~(5'b00100 >> c));
			sense_ok[c] <= 1'b1;
			wait_c(200);
			note(5'b11111 & ~(5'b00100 >> c));
			wait_c(100);
			note(5'b11111);
		end
		low_1v5 <= 1'b0;
		high_1v5 <= 1'b0;
		wait_c(5);
		note(5'b00001);
		low_1v5 <= 1'b1;
		high_1v5 <= 1'b1;
		wait_c(320);
		note(5'b11111);
		wait_c(3);
		complete_run();
	end
endmodule // tb_dual_supply_reset_supervisor
`default_nettype wire
